// [bench/rff_chk.sv]
// Port checker for the receive frame filter
`timescale 1ns/1ps
`default_nettype none
module rff_chk (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_fcf_valid,
  input wire logic [15:0] i_fcf,
  input wire logic o_result_valid,
  input wire logic o_accept,
  input wire logic [15:0] o_fcf
);
  import rff_pkg::*;
  logic rd_a;
  logic rd_b;
  assign rd_a = o_pready && !i_pwrite && ((i_paddr & RFF_ADDR_MASK) == RFF_ADDR_CFG_A);
  assign rd_b = o_pready && !i_pwrite && ((i_paddr & RFF_ADDR_MASK) == RFF_ADDR_CFG_B);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_result_next: assert property (i_fcf_valid |=> o_result_valid)
    else $error("result missing after frame");
  a_result_only: assert property (!i_fcf_valid |=> !o_result_valid)
    else $error("result without frame");
  a_fcf_copy: assert property (i_fcf_valid |=> o_fcf == $past(i_fcf))
    else $error("frame copy altered");
  a_result_hold: assert property (!i_fcf_valid |=> $stable(o_accept) && $stable(o_fcf))
    else $error("result changed without frame");
  a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  a_err_read0: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error response malformed");
  a_rsv_zero: assert property (rd_a |-> o_prdata[31:7] == 25'h0)
    else $error("reserved bits read nonzero");
  a_rsv_zero_b: assert property (rd_b |-> o_prdata[31:8] == 24'h0 && !o_prdata[0])
    else $error("reserved bits of second register read nonzero");
  c_accept: cover property (o_result_valid && o_accept);
  c_reject: cover property (o_result_valid && !o_accept);
  c_slverr: cover property (o_pslverr);
endmodule : rff_chk
bind rff_top rff_chk rff_chk_i (.*);
`default_nettype wire

// [bench/rff_radio.sv]
// Radio receiver model handing frame control fields to the filter
`timescale 1ns/1ps
`default_nettype none
module rff_radio (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_word,
  output logic o_valid = 1'b0,
  output logic [15:0] o_fcf = 16'h0
);
  // Idle data line flips so a stale word never looks fresh
  always_ff @(posedge i_clk) begin
    o_valid <= i_go;
    o_fcf <= i_go ? i_word : ~o_fcf;
  end
endmodule : rff_radio
`default_nettype wire

// [bench/rff_tb_top.sv]
// Self-checking bench for the receive frame filter
`timescale 1ns/1ps
`default_nettype none
module rff_tb_top;
  import rff_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
  logic [31:0] pa = 32'h0, pwd = 32'h0, prd, s = 32'd94542;
  logic pready, perr, fv, rv, acc;
  logic [15:0] word = 16'h0, fcf, ofcf;
  logic [16:0] q[$];
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [7:0] n_acc = 8'h0, n_rej = 8'h0;
  logic [3:0] lastf = 4'h0;
  always #20 clk = ~clk;
  rff_radio rff_radio_i (.i_clk(clk), .i_go(go), .i_word(word), .o_valid(fv), .o_fcf(fcf));
  rff_top rff_top_i (.i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(pready), .o_prdata(prd),
    .o_pslverr(perr), .i_fcf_valid(fv), .i_fcf(fcf), .o_result_valid(rv),
    .o_accept(acc), .o_fcf(ofcf));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  // Failed checks {dst, type, ver, rsv}; none counted while filtering is off
  function automatic logic [3:0] ref_fail(logic [7:0] a, logic [7:0] b, logic [15:0] f);
    logic [2:0] t;
    logic [3:0] r;
    t = f[2:0];
    if (b[2:1] == 2'h1) t[2] = ~t[2];
    if (b[2:1] == 2'h2) t[2] = 1'b0;
    if (b[2:1] == 2'h3) t[2] = 1'b1;
    r[0] = |(a[6:4] & f[9:7]);
    r[1] = f[13:12] > a[3:2];
    r[2] = t[2] ? !b[7] : !b[3 + t[1:0]];
    r[3] = f[11:10] == 2'h0 && (t == 3'h1 || t == 3'h3) && !a[1];
    return a[0] ? r : 4'h0;
  endfunction : ref_fail
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] wd, input logic [32:0] ex);
    psel <= 1'b1;
    pwr <= w;
    pa <= ad;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk("prdata", ex[31:0], prd);
    chk("pslverr", {31'h0, ex[32]}, {31'h0, perr});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic frames(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] f;
    logic [3:0] fl;
    for (int i = 0; i < 8; i++) begin
      f = rnd();
      if (b[2:1] != 2'h0) f[10] = 1'b1;
      fl = ref_fail(a, b, f);
      go <= 1'b1;
      word <= f;
      q.push_back({~|fl, f});
      if (|fl) n_rej++;
      else n_acc++;
      lastf = fl;
      @(posedge clk);
    end
    go <= 1'b0;
    @(posedge clk);
  endtask : frames
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
    if (rv === 1'b1) begin
      if (q.size() == 0) chk("spurious", 32'h0, 32'h1);
      else begin
        chk("accept", {31'h0, q[0][16]}, {31'h0, acc});
        chk("fcf", {16'h0, q[0][15:0]}, {16'h0, ofcf});
        void'(q.pop_front());
      end
    end
  end
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    logic [7:0] a, b;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, RFF_ADDR_CFG_A, 32'h0, {25'h0, 8'h0d});
    apb(1'b0, RFF_ADDR_CFG_B, 32'h0, {25'h0, 8'h78});
    apb(1'b0, 32'h6190, 32'h0, {1'b1, 32'h0});
    frames(8'h0d, 8'h78);
    apb(1'b0, RFF_ADDR_STATUS, 32'h0, {13'h0, lastf, n_rej, n_acc});
    apb(1'b1, RFF_ADDR_CFG_A, 32'hff, 33'h0);
    apb(1'b0, RFF_ADDR_CFG_A, 32'h0, 33'h7f);
    for (int k = 0; k < 40; k++) begin
      a = rnd() & 8'h7f;
      b = rnd() & 8'hfe;
      apb(1'b1, RFF_ADDR_CFG_A, {24'h0, a}, 33'h0);
      apb(1'b1, RFF_ADDR_CFG_B, {24'h0, b}, 33'h0);
      apb(1'b0, RFF_ADDR_CFG_B, 32'h0, {25'h0, b});
      frames(a, b);
      apb(1'b0, RFF_ADDR_STATUS, 32'h0, {13'h0, lastf, n_rej, n_acc});
    end
    repeat (3) @(posedge clk);
    chk("pending", 32'h0, q.size());
    wrap_up();
  end
endmodule : rff_tb_top
`default_nettype wire

// [hw/rff_decide.sv]
// Combinational accept/reject decision for one frame control field
`timescale 1ns/1ps
`default_nettype none
module rff_decide (
  input wire logic [15:0] i_fcf,
  input wire logic [7:0] i_cfg_a,
  input wire logic [7:0] i_cfg_b,
  output logic o_accept,
  output logic [3:0] o_fail
);
  import rff_pkg::*;
  logic [2:0] ftype;
  logic rsv_fail;
  logic ver_fail;
  logic type_fail;
  logic dst_fail;
  logic [1:0] ovr;

  always_comb begin
    ovr = i_cfg_b[RFF_B_OVR_LO +: 2];
    ftype = i_fcf[RFF_FCF_TYPE_LO +: 3];
    case (ovr)
      RFF_OVR_INV: ftype[RFF_FCF_TYPE_MSB] = ~ftype[RFF_FCF_TYPE_MSB];
      RFF_OVR_CLR: ftype[RFF_FCF_TYPE_MSB] = 1'b0;
      RFF_OVR_SET: ftype[RFF_FCF_TYPE_MSB] = 1'b1;
      default: ftype = ftype;
    endcase
    rsv_fail = |(i_cfg_a[RFF_A_RMASK_LO +: 3] & i_fcf[RFF_FCF_RSV_LO +: 3]);
    ver_fail = i_fcf[RFF_FCF_VER_LO +: 2] > i_cfg_a[RFF_A_VER_LO +: 2];
    case (ftype)
      RFF_FT_BEACON: type_fail = ~i_cfg_b[RFF_B_BEACON];
      RFF_FT_DATA: type_fail = ~i_cfg_b[RFF_B_DATA];
      RFF_FT_ACK: type_fail = ~i_cfg_b[RFF_B_ACK];
      RFF_FT_CMD: type_fail = ~i_cfg_b[RFF_B_CMD];
      default: type_fail = ~i_cfg_b[RFF_B_RSVD];
    endcase
    // Only the coordinator takes data/command frames without a destination
    dst_fail = (i_fcf[RFF_FCF_DMODE_LO +: 2] == RFF_DMODE_NONE) &&
               ((ftype == RFF_FT_DATA) || (ftype == RFF_FT_CMD)) &&
               ~i_cfg_a[RFF_A_COORD];
    o_fail = {dst_fail, type_fail, ver_fail, rsv_fail};
    // Disabled filter ignores every other field
    o_accept = ~i_cfg_a[RFF_A_EN] | ~(|o_fail);
  end
endmodule : rff_decide
`default_nettype wire

// [hw/rff_pkg.sv]
// Package for the receive frame filter: register map, fields, reset values
package rff_pkg;
  // Register indices; each register takes one word, byte address is four times the index
  localparam logic [31:0] RFF_IDX_CFG_A = 32'h0000_6180;
  localparam logic [31:0] RFF_IDX_CFG_B = 32'h0000_6181;
  // Diagnostics slot of our own, placement is arbitrary
  localparam logic [31:0] RFF_IDX_STATUS = 32'h0000_61fc;
  localparam logic [31:0] RFF_ADDR_CFG_A = RFF_IDX_CFG_A << 2;
  localparam logic [31:0] RFF_ADDR_CFG_B = RFF_IDX_CFG_B << 2;
  localparam logic [31:0] RFF_ADDR_STATUS = RFF_IDX_STATUS << 2;
  localparam logic [31:0] RFF_ADDR_MASK = 32'hffff_fffc;
  localparam logic [7:0] RFF_CFG_A_RESET = 8'h0d;
  localparam logic [7:0] RFF_CFG_B_RESET = 8'h78;
  localparam logic [7:0] RFF_CFG_A_WMASK = 8'h7f;
  localparam logic [7:0] RFF_CFG_B_WMASK = 8'hfe;
  localparam int RFF_A_EN = 0;
  localparam int RFF_A_COORD = 1;
  localparam int RFF_A_VER_LO = 2;
  localparam int RFF_A_RMASK_LO = 4;
  localparam int RFF_B_OVR_LO = 1;
  localparam int RFF_B_BEACON = 3;
  localparam int RFF_B_DATA = 4;
  localparam int RFF_B_ACK = 5;
  localparam int RFF_B_CMD = 6;
  localparam int RFF_B_RSVD = 7;
  localparam int RFF_FCF_TYPE_LO = 0;
  localparam int RFF_FCF_TYPE_MSB = 2;
  localparam int RFF_FCF_RSV_LO = 7;
  localparam int RFF_FCF_DMODE_LO = 10;
  localparam int RFF_FCF_VER_LO = 12;
  localparam logic [1:0] RFF_OVR_KEEP = 2'h0;
  localparam logic [1:0] RFF_OVR_INV = 2'h1;
  localparam logic [1:0] RFF_OVR_CLR = 2'h2;
  localparam logic [1:0] RFF_OVR_SET = 2'h3;
  localparam logic [2:0] RFF_FT_BEACON = 3'h0;
  localparam logic [2:0] RFF_FT_DATA = 3'h1;
  localparam logic [2:0] RFF_FT_ACK = 3'h2;
  localparam logic [2:0] RFF_FT_CMD = 3'h3;
  localparam logic [1:0] RFF_DMODE_NONE = 2'h0;
  typedef enum logic [1:0] {
    RFF_APB_IDLE = 2'b01,
    RFF_APB_DONE = 2'b10
  } rff_apb_t;
endpackage : rff_pkg

// [hw/rff_top.sv]
// Receive frame filter top: APB registers, frame intake and decision output
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rff_top (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_fcf_valid,
  input wire logic [15:0] i_fcf,
  output logic o_result_valid,
  output logic o_accept,
  output logic [15:0] o_fcf
);
  import rff_pkg::*;
  logic rst_meta_q;
  logic rst_sync_q;
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [3:0] last_fail_q;
  logic [7:0] acc_cnt_q;
  logic [7:0] rej_cnt_q;
  rff_apb_t apb_q;
  logic dec_accept;
  logic [3:0] dec_fail;
  logic setup;
  logic [31:0] rd_d;
  logic hit;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] r);
    addr_is = (a & RFF_ADDR_MASK) == r;
  endfunction : addr_is

  // No wait states: setup is seen, answer raised for the access cycle
  assign setup = i_psel && !i_penable;

  always_comb begin
    hit = 1'b1;
    rd_d = 32'h0;
    if (addr_is(i_paddr, RFF_ADDR_CFG_A)) begin
      rd_d = {24'h0, cfg_a_q};
    end else if (addr_is(i_paddr, RFF_ADDR_CFG_B)) begin
      rd_d = {24'h0, cfg_b_q};
    end else if (addr_is(i_paddr, RFF_ADDR_STATUS)) begin
      rd_d = {12'h0, last_fail_q, rej_cnt_q, acc_cnt_q};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      apb_q <= RFF_APB_IDLE;
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      case (apb_q)
        RFF_APB_IDLE: begin
          if (setup) begin
            apb_q <= RFF_APB_DONE;
            o_pready <= 1'b1;
            o_pslverr <= ~hit;
            o_prdata <= i_pwrite ? 32'h0 : rd_d;
          end
        end
        RFF_APB_DONE: begin
          apb_q <= RFF_APB_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
          o_prdata <= 32'h0;
        end
        default: apb_q <= RFF_APB_IDLE;
      endcase
    end
  end

  // Writes land on the access edge; reserved bits are kept at zero
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cfg_a_q <= RFF_CFG_A_RESET;
      cfg_b_q <= RFF_CFG_B_RESET;
    end else if (i_psel && i_penable && o_pready && i_pwrite) begin
      if (addr_is(i_paddr, RFF_ADDR_CFG_A)) begin
        cfg_a_q <= i_pwdata[7:0] & RFF_CFG_A_WMASK;
      end
      if (addr_is(i_paddr, RFF_ADDR_CFG_B)) begin
        cfg_b_q <= i_pwdata[7:0] & RFF_CFG_B_WMASK;
      end
    end
  end

  rff_decide u_decide (
    .i_fcf(i_fcf),
    .i_cfg_a(cfg_a_q),
    .i_cfg_b(cfg_b_q),
    .o_accept(dec_accept),
    .o_fail(dec_fail)
  );

  // Decision registered one cycle after the field arrives
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      o_result_valid <= 1'b0;
      o_accept <= 1'b0;
      o_fcf <= 16'h0;
    end else begin
      o_result_valid <= i_fcf_valid;
      if (i_fcf_valid) begin
        o_accept <= dec_accept;
        o_fcf <= i_fcf;
      end
    end
  end

  // Status counters wrap; they are diagnostics, not flow control
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      last_fail_q <= 4'h0;
      acc_cnt_q <= 8'h0;
      rej_cnt_q <= 8'h0;
    end else if (i_fcf_valid) begin
      last_fail_q <= cfg_a_q[RFF_A_EN] ? dec_fail : 4'h0;
      if (dec_accept) begin
        acc_cnt_q <= acc_cnt_q + 8'h1;
      end else begin
        rej_cnt_q <= rej_cnt_q + 8'h1;
      end
    end
  end
endmodule : rff_top
`default_nettype wire
